// ==== src/wdgt_pkg.sv ====
// Package of constants for the watchdog timer block
package wdgt_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0]  WDGT_CTRL_IDX     = 8'h33;        // Control register index
   localparam logic [31:0] WDGT_CTRL_ADDR    = 32'h000000cc; // Byte address, index times four
   localparam logic [7:0]  WDGT_CTRL_RESET   = 8'h7f;        // Control reset value
   localparam int          WDGT_ACT_BIT      = 7;            // Activate bit position
   localparam int          WDGT_TOP_BIT      = 6;            // Counter top bit position
   localparam logic [6:0]  WDGT_CNT_EXPIRE   = 7'h40;        // Value just before expiry
   localparam logic [6:0]  WDGT_CNT_ONE      = 7'h01;        // Decrement step
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          WDGT_PRESCALE     = 16000;        // Machine cycles per count
   localparam logic [13:0] WDGT_PRE_LAST     = 14'(WDGT_PRESCALE - 1);
   localparam logic [13:0] WDGT_PRE_ONE      = 14'h0001;     // Prescaler step
   localparam int          WDGT_RST_NS       = 30000;        // Reset pulse length in ns
   localparam int          WDGT_CLK_NS       = 50;           // Clock period in ns
   localparam logic [9:0]  WDGT_RST_CYCLES   = 10'((WDGT_RST_NS + WDGT_CLK_NS - 1) / WDGT_CLK_NS);
   localparam logic [9:0]  WDGT_RST_ONE      = 10'h001;      // Reset counter step
   // -----------------------------------------------------------------
   // AHB encodings
   // -----------------------------------------------------------------
   localparam logic [1:0]  WDGT_HTRANS_NSEQ  = 2'h2;         // Nonsequential transfer
   localparam logic        WDGT_HRESP_OKAY   = 1'b0;         // Okay response
endpackage : wdgt_pkg

// ==== src/wdgt_prescaler.sv ====
// Free-running machine-cycle prescaler for the watchdog timer
`timescale 1ns/1ps
module wdgt_prescaler (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Tick out, one cycle every prescale period
   output logic      tick
);
   import wdgt_pkg::*;

   logic [13:0] preCnt_reg;   // Cycle count within the period
   logic [13:0] preCnt_next;  // Next cycle count
   logic        tick_reg;     // Registered tick
   logic        tick_next;    // Next tick

   // Never restarted by software, so refresh phase is unknown
   always_comb begin
      if (preCnt_reg == WDGT_PRE_LAST) begin
         preCnt_next = '0;
         tick_next   = 1'b1;
      end else begin
         preCnt_next = preCnt_reg + WDGT_PRE_ONE;
         tick_next   = 1'b0;
      end
   end

   // Register the prescaler
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         preCnt_reg <= '0;
         tick_reg   <= 1'b0;
      end else begin
         preCnt_reg <= preCnt_next;
         tick_reg   <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule : wdgt_prescaler

// ==== src/wdgt_watchdog_timer.sv ====
// Watchdog timer with AHB-Lite control register and reset generator
//
// Behaviour
// - Count decrements once every 16000 cycles
// - Active and 40h to 3Fh starts reset
// - Counter decrements even when not active
// - Inactive after reset; activate only set
// - Activate with top bit clear resets
// - Halt while active resets unless option
// - Hardware option forces always active
// - Timeout spread from free prescaler phase
// - Control register resets to 7Fh
//
// A write lands at the end of its data phase and wins over a
// prescaler tick in the same cycle, so a refresh never loses to
// an expiry that falls on the same edge.
// The block only requests a reset; the system reset that follows
// comes back on reset_n from the surrounding logic.
// The prescaler phase is never cleared by software, so the time
// to expiry after a refresh varies by up to one prescale period.
// Once active, any write with the top count bit clear is a
// software reset, with or without the hardware option.
`timescale 1ns/1ps
module wdgt_watchdog_timer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Option settings and CPU status
   input  wire logic        hwWatchdogOption,
   input  wire logic        halt_without_reset_option,
   input  wire logic        haltExecuted,
   // Reset request, active low
   output logic             wdgResetOut_n
);
   import wdgt_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic        tick;                  // Prescaler tick
   logic        watchdog_activate_reg; // Activate bit
   logic        watchdog_activate_next;
   logic [6:0]  count_reg;             // Countdown value
   logic [6:0]  count_next;
   logic        wrPend_reg;            // Write data phase pending
   logic        wrPend_next;
   logic        addrPhase;             // Valid address phase, any address
   logic        resetEvent;            // Any event that starts a pulse
   logic [31:0] hrdata_reg;            // Read data
   logic [31:0] hrdata_next;
   logic [9:0]  rstCnt_reg;            // Reset pulse remaining cycles
   logic [9:0]  rstCnt_next;
   logic        rstOut_n_reg;          // Registered reset output
   logic        rstOut_n_next;
   // Reset pulse generator states, one-hot
   typedef enum logic [1:0] {
      RST_IDLE  = 2'h1,   // Pin released, waiting for an event
      RST_PULSE = 2'h2    // Pin held low, counting down
   } wdgt_rst_state_t;
   wdgt_rst_state_t rstState_reg;  // Pulse generator state
   wdgt_rst_state_t rstState_next; // Next pulse generator state
   logic        active;                // Effective activation
   logic        addrHit;               // Address phase to control
   logic        expire;                // Countdown expiry event
   logic        swReset;               // Software reset event
   logic        haltReset;             // Halt reset event

   // Decode a valid address phase to the control word
   function automatic logic hitCtrl(input logic [31:0] a);
      hitCtrl = (a == WDGT_CTRL_ADDR);
   endfunction : hitCtrl

   // -----------------------------------------------------------------
   // Prescaler
   // -----------------------------------------------------------------
   wdgt_prescaler u_prescaler (
      .clk     (clk),
      .reset_n (reset_n),
      .tick    (tick)
   );

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   // Only a selected, ready, nonsequential phase is taken
   assign addrPhase = hsel && hready && (htrans == WDGT_HTRANS_NSEQ);
   // Only the control word is mapped; other addresses are holes
   assign addrHit   = addrPhase && hitCtrl(haddr);

   // Latch address phase; zero-wait data phase; unmapped reads as zero
   always_comb begin
      wrPend_next = addrHit && hwrite;   // Write data follows next cycle
      hrdata_next = hrdata_reg;          // Held until the next read
      if (addrPhase && !hwrite) begin
         // Unmapped reads return zero
         hrdata_next = '0;
         if (addrHit) begin
            // Next values, so a write in its data phase is already seen
            hrdata_next = {24'h000000, watchdog_activate_next, count_next};
         end
      end
   end

   // Register the bus slave state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPend_reg <= 1'b0;
         hrdata_reg <= '0;
      end else begin
         wrPend_reg <= wrPend_next;
         hrdata_reg <= hrdata_next;
      end
   end

   // -----------------------------------------------------------------
   // Watchdog core
   // -----------------------------------------------------------------
   // Hardware option forces active, activate bit then unused
   assign active = hwWatchdogOption || watchdog_activate_reg;

   // Written activate state, used for software reset detection
   assign swReset = wrPend_reg && (hwdata[WDGT_ACT_BIT] || active)
                    && !hwdata[WDGT_TOP_BIT];
   // Expiry when the counter passes 40h to 3Fh while active
   assign expire = active && tick && !wrPend_reg
                   && (count_reg == WDGT_CNT_EXPIRE);
   // Halt reset unless the option keeps the watchdog quiet
   assign haltReset = active && haltExecuted && !halt_without_reset_option;

   // Next count and activation
   always_comb begin
      watchdog_activate_next = watchdog_activate_reg;
      count_next             = count_reg;
      if (tick) begin
         count_next = count_reg - WDGT_CNT_ONE;
      end
      if (wrPend_reg) begin
         count_next = hwdata[WDGT_TOP_BIT:0];
         if (hwdata[WDGT_ACT_BIT]) begin
            watchdog_activate_next = 1'b1;
         end
      end
   end

   // Any of the three events starts or restarts the pulse
   assign resetEvent = expire || swReset || haltReset;

   // Reset pulse generator, retriggered by each new event
   always_comb begin
      rstState_next = rstState_reg;
      rstCnt_next   = rstCnt_reg;
      rstOut_n_next = 1'b1;
      case (rstState_reg)
         RST_IDLE: begin
            // Pin released until an event arrives
            if (resetEvent) begin
               rstState_next = RST_PULSE;
               rstCnt_next   = WDGT_RST_CYCLES;
               rstOut_n_next = 1'b0;
            end
         end
         RST_PULSE: begin
            // Pin held low while the count runs down
            rstOut_n_next = 1'b0;
            if (resetEvent) begin
               rstCnt_next = WDGT_RST_CYCLES;
            end else if (rstCnt_reg == WDGT_RST_ONE) begin
               rstState_next = RST_IDLE;
               rstCnt_next   = '0;
               rstOut_n_next = 1'b1;
            end else begin
               rstCnt_next = rstCnt_reg - WDGT_RST_ONE;
            end
         end
         default: begin
            // Illegal code, return to idle with the pin released
            rstState_next = RST_IDLE;
            rstCnt_next   = '0;
         end
      endcase
   end

   // Register the watchdog core
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_activate_reg <= WDGT_CTRL_RESET[WDGT_ACT_BIT];
         count_reg             <= WDGT_CTRL_RESET[WDGT_TOP_BIT:0];
      end else begin
         watchdog_activate_reg <= watchdog_activate_next;
         count_reg             <= count_next;
      end
   end

   // Register the reset pulse generator
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstState_reg <= RST_IDLE;
         rstCnt_reg   <= '0;
         rstOut_n_reg <= 1'b1;
      end else begin
         rstState_reg <= rstState_next;
         rstCnt_reg   <= rstCnt_next;
         rstOut_n_reg <= rstOut_n_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign hrdata        = hrdata_reg;
   assign hreadyout     = 1'b1;
   assign hresp         = WDGT_HRESP_OKAY;
   assign wdgResetOut_n = rstOut_n_reg;
endmodule : wdgt_watchdog_timer

// ==== tb/wdgt_watchdog_timer_properties.sv ====
// Concurrent checks on the ports of the watchdog timer
`timescale 1ns/1ps
module wdgt_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Options, status and reset out
   input wire logic        hwWatchdogOption,
   input wire logic        halt_without_reset_option,
   input wire logic        haltExecuted,
   input wire logic        wdgResetOut_n
);
   import wdgt_pkg::*;
   logic       wr_reg, wr_next, rd_reg, rd_next, act_reg, act_next; // Data phase, activate seen
   logic [9:0] low_reg, low_next;                                  // Cycles of reset low
   // Next state of the tracking logic
   always_comb begin
      wr_next = hsel && hready && htrans == WDGT_HTRANS_NSEQ && haddr == WDGT_CTRL_ADDR;
      rd_next = wr_next && !hwrite;
      wr_next = wr_next && hwrite;
      act_next = act_reg || (wr_reg && hwdata[WDGT_ACT_BIT]);
      low_next = wdgResetOut_n ? 10'h000 : low_reg + WDGT_RST_ONE;
   end
   // Tracking registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {wr_reg, rd_reg, act_reg, low_reg} <= '0;
      end else begin
         {wr_reg, rd_reg, act_reg, low_reg} <= {wr_next, rd_next, act_next, low_next};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_okay; hreadyout && hresp == WDGT_HRESP_OKAY; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or not okay");
   property p_upper; hrdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   property p_start; $rose(reset_n) |-> wdgResetOut_n; endproperty
   a_start: assert property (p_start) else $error("reset out low after reset");
   property p_len; $rose(wdgResetOut_n) |-> low_reg == WDGT_RST_CYCLES; endproperty
   a_len: assert property (p_len) else $error("reset pulse length wrong");
   property p_halt;
      haltExecuted && (act_reg || hwWatchdogOption) && !halt_without_reset_option
         |=> !wdgResetOut_n;
   endproperty
   a_halt: assert property (p_halt) else $error("halt gave no reset");
   property p_quiet;
      haltExecuted && !act_reg && !hwWatchdogOption && !wr_reg && wdgResetOut_n
         |=> wdgResetOut_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("halt reset while inactive");
   property p_soft; wr_reg && hwdata[7:6] == 2'h2 |=> !wdgResetOut_n; endproperty
   a_soft: assert property (p_soft) else $error("software reset missing");
   property p_sticky; rd_reg && act_reg |-> hrdata[WDGT_ACT_BIT]; endproperty
   a_sticky: assert property (p_sticky) else $error("activate bit cleared");
endmodule : wdgt_checker

bind wdgt_watchdog_timer wdgt_checker chk (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .hwWatchdogOption,
   .halt_without_reset_option, .haltExecuted, .wdgResetOut_n);

// ==== tb/wdgt_watchdog_timer_test.sv ====
// Self-checking testbench of the watchdog timer
`timescale 1ns/1ps
module wdgt_watchdog_timer_test;
   import wdgt_pkg::*;
   typedef struct packed {logic w; logic [31:0] a; logic [7:0] d; logic [7:0] e;} wdgt_row_t;
   localparam wdgt_row_t ROWS [6] = '{'{1'b0, 32'hcc, 8'h00, 8'h7f},
      '{1'b1, 32'hc8, 8'h00, 8'h00}, '{1'b0, 32'hcc, 8'h00, 8'h7f},
      '{1'b0, 32'hc8, 8'h00, 8'h00}, '{1'b1, 32'hcc, 8'h40, 8'h00},
      '{1'b0, 32'hcc, 8'h00, 8'h40}};
   logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, wdgResetOut_n, seen;
   logic        haltExecuted, halt_without_reset_option, hwWatchdogOption;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, r0, r1;
   int          n_fail = 0, checks_done = 0;
   wdgt_watchdog_timer dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hwWatchdogOption(hwWatchdogOption),
      .halt_without_reset_option(halt_without_reset_option), .haltExecuted(haltExecuted),
      .wdgResetOut_n(wdgResetOut_n));
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // One single AHB-Lite transfer, address phase then data phase
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= WDGT_HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer
   task check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask : check
   // Watch reset out for a span of cycles
   task waitp(input int lim);
      seen = 1'b0;
      repeat (lim) begin
         @(posedge clk);
         if (wdgResetOut_n === 1'b0) seen = 1'b1;
      end
   endtask : waitp
   task halt_pulse;
      haltExecuted <= 1'b1;
      @(posedge clk);
      haltExecuted <= 1'b0;
   endtask : halt_pulse
   task do_reset;
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset
   task print_verdict;
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // Watchdog of the run
   initial begin
      #3000000;
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {haltExecuted, halt_without_reset_option, hwWatchdogOption} = 3'h0;
      do_reset();
      check(wdgResetOut_n, 1'b1);
      foreach (ROWS[i]) begin
         xfer(ROWS[i].w, ROWS[i].a, {24'h0, ROWS[i].d}, r0);
         if (!ROWS[i].w) check(r0, {24'h0, ROWS[i].e});
      end
      halt_pulse();
      waitp(20);
      check(seen, 1'b0);
      xfer(1'b0, WDGT_CTRL_ADDR, 32'h0, r0);
      check(r0, 32'h40);
      repeat (15998) @(posedge clk);
      xfer(1'b0, WDGT_CTRL_ADDR, 32'h0, r1);
      check(r1, 32'h3f);
      xfer(1'b1, WDGT_CTRL_ADDR, 32'hc0, r0);
      xfer(1'b0, WDGT_CTRL_ADDR, 32'h0, r0);
      check(r0, 32'hc0);
      waitp(16700);
      check(seen, 1'b1);
      do_reset();
      xfer(1'b0, WDGT_CTRL_ADDR, 32'h0, r0);
      check(r0, 32'h7f);
      xfer(1'b1, WDGT_CTRL_ADDR, 32'hff, r0);
      xfer(1'b1, WDGT_CTRL_ADDR, 32'h7f, r0);
      xfer(1'b0, WDGT_CTRL_ADDR, 32'h0, r0);
      check(r0, 32'hff);
      xfer(1'b1, WDGT_CTRL_ADDR, 32'hff, r0);
      halt_without_reset_option <= 1'b1;
      halt_pulse();
      waitp(30);
      check(seen, 1'b0);
      halt_without_reset_option <= 1'b0;
      halt_pulse();
      waitp(700);
      check(seen, 1'b1);
      do_reset();
      xfer(1'b1, WDGT_CTRL_ADDR, 32'h80, r0);
      waitp(700);
      check(seen, 1'b1);
      do_reset();
      hwWatchdogOption <= 1'b1;
      halt_pulse();
      waitp(700);
      check(seen, 1'b1);
      print_verdict();
   end
endmodule : wdgt_watchdog_timer_test
